/* core/ide_glue_defs.svh */
// constants for the ide decode and rom bus glue
`ifndef IDE_GLUE_DEFS_SVH
`define IDE_GLUE_DEFS_SVH
`define PRI_TASK_BASE 10'h1F0
`define SEC_TASK_BASE 10'h170
`define PRI_CTRL_ADDR 10'h3F6
`define SEC_CTRL_ADDR 10'h376
`define TASK_DATA_OFS 3'h0
`define TASK_FILE_SPAN 10'h008
`define KBC_PULSE_CLKS 4'h3
`define KBC_RISE_NS 20
`define CLK_PERIOD_NS 10
`define KBC_RISE_CLKS ((`KBC_RISE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define KBC_PIN_COUNT 6
`define KBC_PIN_FIRST 2
`endif

/* core/ide_glue_pkg.sv */
// types for the ide decode and rom bus glue
package ide_glue_pkg;
  // pin role on a rom-side pin
  typedef enum logic [1:0] {
    role_rom_bus = 2'b00,
    role_general = 2'b01,
    role_kbc = 2'b11
  } pin_role_e;
  // drive state of one keyboard-controller port pin
  typedef enum logic [1:0] {
    kbc_low = 2'b00,
    kbc_boost = 2'b01,
    kbc_held = 2'b11
  } kbc_state_e;
endpackage

/* core/kbc_port_pin.sv */
// one keyboard-controller port pin driver with temporary high boost
`timescale 1ns/100ps
`include "ide_glue_defs.svh"
module kbc_port_pin #(
  parameter int unsigned BOOST_CLKS = `KBC_PULSE_CLKS
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // control
  input wire logic active,
  input wire logic port_value,
  input wire logic open_drain,
  // pin drive
  output logic pin_out,
  output logic pin_oe,
  output logic pullup_on
);
  ide_glue_pkg::kbc_state_e state;
  logic [7:0] count;

  // boost after rising port value, then release to weak pull-up
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ide_glue_pkg::kbc_held;
      count <= 8'h00;
    end else if (!active || !port_value) begin
      state <= ide_glue_pkg::kbc_low;
      count <= 8'h00;
    end else begin
      unique case (state)
        ide_glue_pkg::kbc_low: begin
          state <= open_drain ? ide_glue_pkg::kbc_held : ide_glue_pkg::kbc_boost;
          count <= 8'h00;
        end
        ide_glue_pkg::kbc_boost: begin
          count <= count + 8'h01;
          if (count >= 8'(BOOST_CLKS - 1)) begin
            state <= ide_glue_pkg::kbc_held;
          end
        end
        ide_glue_pkg::kbc_held: begin
          state <= ide_glue_pkg::kbc_held;
        end
        default: begin
          state <= ide_glue_pkg::kbc_held;
        end
      endcase
    end
  end

  // zero drives low; one boosts high unless open drain
  always_comb begin
    pin_out = 1'b0;
    pin_oe = 1'b0;
    pullup_on = 1'b0;
    if (active) begin
      if (!port_value) begin
        pin_oe = 1'b1;
      end else if (open_drain) begin
        pin_oe = 1'b0;
      end else begin
        pin_out = 1'b1;
        pin_oe = (state != ide_glue_pkg::kbc_held);
        pullup_on = 1'b1;
      end
    end
  end

  a_boost_first_cycle: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (active && !open_drain && $rose(port_value)) |-> pin_oe && pin_out)
    else $error("no active high drive after port value one");
  a_open_drain_float: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (active && open_drain && port_value) |-> !pin_oe)
    else $error("open drain pin driven while port value one");
  a_boost_ends: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (active && !open_drain && $rose(port_value) && $stable(open_drain))
      ##1 (active && port_value && !open_drain) [*5] |-> !pin_oe)
    else $error("temporary drive lasted too long");
endmodule

/* core/ide_rom_glue.sv */
// ide channel decode, buffer enables and rom-side byte buffer
//
// Functional notes
// - both channels decode host access, drive buffer enables
// - low data byte passes through internal buffer
// - task file selected when its select low
// - control register selected when its select low
// - offset zero is word wide, rest bytes
// - buffer enables act as for word transfers
// - option one: each channel own enable
// - option two: first enable serves both channels
// - first channel drive selects reprogrammable as decoders
// - rom buffer passes, reverses or isolates per controls
// - alternate-function pins read through, write alternate value
// - output enable alternate: internally low, read only
// - buffer enable alternate: internally high, bus floats
// - kbc one: brief active high, then pull-up
// - open drain kbc: no boost, one floats
// - kbc role ignores input and invert settings
// - kbc functions on six upper rom pins
// - reset makes all general pins plain inputs
`timescale 1ns/100ps
`include "ide_glue_defs.svh"
module ide_rom_glue #(
  parameter int unsigned BOOST_CLKS = `KBC_PULSE_CLKS,
  parameter logic [9:0] DEC_A_ADDR = 10'h000,
  parameter logic [9:0] DEC_B_ADDR = 10'h000
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // host bus
  input wire logic [9:0] host_addr,
  input wire logic host_ior_b,
  input wire logic host_iow_b,
  input wire logic host_aen,
  // channel chip selects from host decode
  input wire logic primary_taskfile_select_b,
  input wire logic secondary_taskfile_select_b,
  input wire logic primary_control_select_b,
  input wire logic secondary_control_select_b,
  // configuration
  input wire logic shared_buffer_option,
  input wire logic decoder_config_a,
  input wire logic decoder_config_b,
  // ide outputs
  output logic first_channel_buffer_enable_b,
  output logic second_channel_buffer_enable_b,
  output logic drive_select_low_group_b,
  output logic drive_select_high_group_b,
  output logic ide_word_access,
  // ide low data byte
  input wire logic [7:0] ide_low_in,
  output logic [7:0] ide_low_out,
  output logic ide_low_oe,
  // system data bus low byte
  input wire logic [7:0] system_data_bus_in,
  output logic [7:0] system_data_bus_out,
  output logic system_data_bus_oe,
  // rom-side buffer control and pins
  input wire logic rom_buffer_enable_b,
  input wire logic rom_buffer_direction,
  input wire logic rom_output_enable_b,
  input wire logic rom_enable_alternate,
  input wire logic rom_oe_alternate,
  input wire logic [7:0] rom_in,
  output logic [7:0] rom_out,
  output logic [7:0] rom_oe,
  output logic [7:0] rom_pullup,
  // per-pin roles and values
  input wire logic [7:0] pin_alternate,
  input wire logic [7:0] alt_value,
  input wire logic [7:0] kbc_select,
  input wire logic [7:0] kbc_port_value,
  input wire logic [7:0] kbc_open_drain,
  // general-purpose configuration
  input wire logic [7:0] gp_cfg_write,
  input wire logic [7:0] gp_cfg_output,
  input wire logic [7:0] gp_cfg_invert,
  input wire logic [7:0] gp_out_value,
  output logic [7:0] gp_is_output,
  output logic [7:0] gp_is_inverted,
  output logic [7:0] gp_in_value
);
  logic [7:0] ide_low_hold;
  logic [7:0] rom_hold;
  logic [7:0] kbc_out;
  logic [7:0] kbc_oe;
  logic [7:0] kbc_pull;
  logic [7:0] kbc_active;
  logic pri_sel;
  logic sec_sel;
  logic pri_data;
  logic sec_data;
  logic host_rd;
  logic host_wr;
  logic rom_cs_int_b;
  logic rom_oe_int_b;
  logic rom_to_sys;
  logic sys_to_rom;

  // exact single-address match used by both general decoders
  function automatic logic addr_hit(input logic [9:0] a, input logic [9:0] base);
    addr_hit = (a == base);
  endfunction

  // host strobes
  assign host_rd = !host_ior_b && !host_aen;
  assign host_wr = !host_iow_b && !host_aen;

  // channel select decode
  assign pri_sel = !primary_taskfile_select_b || !primary_control_select_b;
  assign sec_sel = !secondary_taskfile_select_b || !secondary_control_select_b;
  assign pri_data = !primary_taskfile_select_b && host_addr[2:0] == `TASK_DATA_OFS;
  assign sec_data = !secondary_taskfile_select_b && host_addr[2:0] == `TASK_DATA_OFS;
  assign ide_word_access = pri_data || sec_data;

  // buffer enables always act as word transfers, per option
  always_comb begin
    first_channel_buffer_enable_b = 1'b1;
    second_channel_buffer_enable_b = 1'b1;
    if ((host_rd || host_wr) && (pri_sel || sec_sel)) begin
      if (shared_buffer_option) begin
        first_channel_buffer_enable_b = 1'b0;
      end else begin
        first_channel_buffer_enable_b = !pri_sel;
        second_channel_buffer_enable_b = !sec_sel;
      end
    end
  end

  // drive selects, optionally reused as general address decoders
  always_comb begin
    drive_select_low_group_b = primary_taskfile_select_b;
    drive_select_high_group_b = primary_control_select_b;
    if (decoder_config_a) begin
      drive_select_low_group_b = !(addr_hit(host_addr, DEC_A_ADDR) && !host_aen);
    end
    if (decoder_config_b) begin
      drive_select_high_group_b = !(addr_hit(host_addr, DEC_B_ADDR) && !host_aen);
    end
  end

  // internal low-byte buffer, latched for timing
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ide_low_hold <= 8'h00;
    end else if (host_rd && (pri_sel || sec_sel)) begin
      ide_low_hold <= ide_low_in;
    end else if (host_wr && (pri_sel || sec_sel)) begin
      ide_low_hold <= system_data_bus_in;
    end
  end

  assign ide_low_out = ide_low_hold;
  assign ide_low_oe = host_wr && (pri_sel || sec_sel);

  // internal rom control levels under alternate functions
  assign rom_cs_int_b = rom_enable_alternate ? 1'b1 : rom_buffer_enable_b;
  assign rom_oe_int_b = rom_oe_alternate ? 1'b0 : rom_output_enable_b;
  // read only when the output-enable pin is alternate (held low inside)
  assign rom_to_sys = !rom_cs_int_b &&
    ((rom_oe_alternate && !rom_oe_int_b) || !rom_buffer_direction);
  assign sys_to_rom = !rom_cs_int_b && !rom_oe_alternate && rom_buffer_direction;

  // rom read data registered onto the system bus
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rom_hold <= 8'h00;
    end else if (rom_to_sys) begin
      rom_hold <= rom_in;
    end else if (host_rd && (pri_sel || sec_sel)) begin
      rom_hold <= ide_low_in;
    end
  end

  assign system_data_bus_out = rom_hold;
  // the buffer table alone steers the byte; the rom's own output enable does not gate it
  assign system_data_bus_oe = rom_to_sys || (host_rd && (pri_sel || sec_sel));

  // kbc pins are the six upper rom pins
  generate
    for (genvar i = 0; i < 8; i++) begin : g_pin
      if (i >= `KBC_PIN_FIRST && i < `KBC_PIN_FIRST + `KBC_PIN_COUNT) begin : g_kbc
        assign kbc_active[i] = kbc_select[i] && pin_alternate[i];
        kbc_port_pin #(
          .BOOST_CLKS(BOOST_CLKS)
        ) u_kbc (
          .sys_clk(sys_clk),
          .rst_b(rst_b),
          .active(kbc_active[i]),
          .port_value(kbc_port_value[i]),
          .open_drain(kbc_open_drain[i]),
          .pin_out(kbc_out[i]),
          .pin_oe(kbc_oe[i]),
          .pullup_on(kbc_pull[i])
        );
      end else begin : g_plain
        assign kbc_active[i] = 1'b0;
        assign kbc_out[i] = 1'b0;
        assign kbc_oe[i] = 1'b0;
        assign kbc_pull[i] = 1'b0;
      end
    end
  endgenerate

  // per-pin rom side drive
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      rom_out[i] = 1'b0;
      rom_oe[i] = 1'b0;
      rom_pullup[i] = kbc_pull[i];
      if (kbc_active[i]) begin
        rom_out[i] = kbc_out[i];
        rom_oe[i] = kbc_oe[i];
      end else if (pin_alternate[i]) begin
        rom_out[i] = alt_value[i] ^ gp_is_inverted[i];
        rom_oe[i] = rom_cs_int_b ? gp_is_output[i] : sys_to_rom;
      end else if (sys_to_rom) begin
        rom_out[i] = system_data_bus_in[i];
        rom_oe[i] = 1'b1;
      end else if (rom_cs_int_b && gp_is_output[i]) begin
        rom_out[i] = gp_out_value[i] ^ gp_is_inverted[i];
        rom_oe[i] = 1'b1;
      end
    end
  end

  // general-purpose direction and polarity; reset gives plain inputs
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      gp_is_output <= 8'h00;
      gp_is_inverted <= 8'h00;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (kbc_active[i]) begin
          gp_is_output[i] <= 1'b1;
          gp_is_inverted[i] <= 1'b0;
        end else if (gp_cfg_write[i]) begin
          gp_is_output[i] <= gp_cfg_output[i];
          gp_is_inverted[i] <= gp_cfg_invert[i];
        end
      end
    end
  end

  // general input sample
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      gp_in_value <= 8'h00;
    end else begin
      gp_in_value <= rom_in ^ gp_is_inverted;
    end
  end

  a_shared_option: assert property (@(posedge sys_clk) disable iff (!rst_b)
    shared_buffer_option |-> second_channel_buffer_enable_b)
    else $error("second enable used in shared option");
  a_own_enable: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!shared_buffer_option && host_rd && !secondary_taskfile_select_b && !pri_sel)
      |-> !second_channel_buffer_enable_b && first_channel_buffer_enable_b)
    else $error("secondary access on wrong enable");
  a_word_enable: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (host_wr && !primary_taskfile_select_b && host_addr[2:0] != 3'h0)
      |-> !first_channel_buffer_enable_b)
    else $error("byte access did not enable buffer");
  a_ctrl_select: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (host_rd && !primary_control_select_b) |-> !first_channel_buffer_enable_b)
    else $error("control select not decoded");
  a_rom_isolate: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (rom_enable_alternate && !(|kbc_active) && !(|pin_alternate) && !(|gp_is_output))
      |-> rom_oe == 8'h00)
    else $error("rom bus driven while buffer disabled");
  a_rom_read: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (rom_to_sys) |=> rom_hold == $past(rom_in))
    else $error("rom data not passed to system bus");
  a_oe_alt_ro: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (rom_oe_alternate && !(|pin_alternate) && !(|gp_is_output)) |-> rom_oe == 8'h00)
    else $error("read only rom bus driven");
  a_kbc_no_input: assert property (@(posedge sys_clk) disable iff (!rst_b)
    kbc_active[2] ##1 kbc_active[2] |-> gp_is_output[2] && !gp_is_inverted[2])
    else $error("kbc pin made input or inverted");
  a_low_byte: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (host_rd && pri_sel) |=> ide_low_out == $past(ide_low_in))
    else $error("low data byte not buffered");
endmodule

/* sim/far_side_model.sv */
// far side model: ide drive low byte and rom-side device
`timescale 1ns/100ps
module far_side_model (
  // clock
  input wire logic clk,
  // ide drive
  input wire logic rd,
  input wire logic [7:0] ide_byte,
  output logic [7:0] ide_in,
  // rom-side device and pins
  input wire logic drv,
  input wire logic [7:0] rom_byte,
  input wire logic [7:0] rom_out,
  input wire logic [7:0] rom_oe,
  input wire logic [7:0] rom_pu,
  output logic [7:0] rom_in
);
  logic [7:0] last_ide = 8'h00;
  logic [7:0] last_rom = 8'h00;
  // released lines toggle so stale data never passes for fresh
  always @(posedge clk) begin
    last_ide <= ide_in;
    last_rom <= rom_in;
  end
  assign ide_in = rd ? ide_byte : ~last_ide;
  // pin level: glue drive, then far device, then weak pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (rom_oe[i])
        rom_in[i] = rom_out[i];
      else if (drv)
        rom_in[i] = rom_byte[i];
      else if (rom_pu[i])
        rom_in[i] = 1'h1;
      else
        rom_in[i] = ~last_rom[i];
    end
  end
endmodule

/* sim/ide_rom_glue_tb.sv */
// bench for the ide decode and rom bus glue
`timescale 1ns/100ps
`define CK(g, e) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, g, e); end end
module ide_rom_glue_tb;
  localparam int BST = 2;
  localparam logic [9:0] AT [4] = '{10'h1F0, 10'h170, 10'h3F6, 10'h376};
  int miscompares = 0;
  int cmp_count = 0;
  int n;
  // clock, reset and host side
  logic clk = 1'h0, rb = 1'h0, ior = 1'h1, iow = 1'h1, aen = 1'h0;
  logic opt = 1'h0, ca = 1'h0, cb = 1'h0, cs = 1'h1, dir = 1'h0, roe = 1'h1;
  logic csa = 1'h0, oea = 1'h0, rdrv = 1'h0;
  logic [9:0] adr = 10'h000;
  logic [3:0] sel = 4'hF;
  logic e1, e2, dl, dh, wd, lo_oe, sd_oe;
  logic [7:0] lo_in, lo_out, sd_out, rin, rout, roen, rpu, gpo, gpi, gin;
  logic [7:0] sd_in = 8'h00, byt = 8'h00, rbyte = 8'h00, alt = 8'h00, aval = 8'h00;
  logic [7:0] ksel = 8'h00, kval = 8'h00, kod = 8'h00, gw = 8'h00, go = 8'h00, gi = 8'h00;
  ide_rom_glue #(.BOOST_CLKS(BST), .DEC_A_ADDR(10'h2A0), .DEC_B_ADDR(10'h2A8)) i_ide_rom_glue (
    .sys_clk(clk), .rst_b(rb), .host_addr(adr), .host_ior_b(ior), .host_iow_b(iow),
    .host_aen(aen), .primary_taskfile_select_b(sel[0]), .secondary_taskfile_select_b(sel[1]),
    .primary_control_select_b(sel[2]), .secondary_control_select_b(sel[3]),
    .shared_buffer_option(opt), .decoder_config_a(ca), .decoder_config_b(cb),
    .first_channel_buffer_enable_b(e1), .second_channel_buffer_enable_b(e2),
    .drive_select_low_group_b(dl), .drive_select_high_group_b(dh), .ide_word_access(wd),
    .ide_low_in(lo_in), .ide_low_out(lo_out), .ide_low_oe(lo_oe),
    .system_data_bus_in(sd_in), .system_data_bus_out(sd_out), .system_data_bus_oe(sd_oe),
    .rom_buffer_enable_b(cs), .rom_buffer_direction(dir), .rom_output_enable_b(roe),
    .rom_enable_alternate(csa), .rom_oe_alternate(oea), .rom_in(rin), .rom_out(rout),
    .rom_oe(roen), .rom_pullup(rpu), .pin_alternate(alt), .alt_value(aval),
    .kbc_select(ksel), .kbc_port_value(kval), .kbc_open_drain(kod), .gp_cfg_write(gw),
    .gp_cfg_output(go), .gp_cfg_invert(gi), .gp_out_value(8'h00), .gp_is_output(gpo),
    .gp_is_inverted(gpi), .gp_in_value(gin));
  far_side_model i_far_side_model (.clk(clk), .rd(~ior), .ide_byte(byt), .ide_in(lo_in),
    .drv(rdrv), .rom_byte(rbyte), .rom_out(rout), .rom_oe(roen), .rom_pu(rpu), .rom_in(rin));
  // 100 MHz clock
  initial begin
    forever #5 clk = ~clk;
  end
  // wait edges, then step past them
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // host cycle: read or write strobe with selects and address
  task automatic hst(input logic r, input logic [3:0] s, input logic [9:0] a);
    tick(1);
    ior = ~r;
    iow = r;
    sel = s;
    adr = a;
    #1;
  endtask
  task automatic fin(input string t);
    $display("test %s done", t);
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    `CK(gpo, 8'h00)
    `CK(gpi, 8'h00)
    #1 rb = 1'h1;
    tick(1);
    // every select under both enable options
    for (int o = 0; o < 2; o++) begin
      opt = o[0];
      for (int s = 0; s < 4; s++) begin
        hst(1'h1, ~(4'h1 << s), AT[s]);
        `CK(e1, (s[0] && !o[0]) ? 1'h1 : 1'h0)
        `CK(e2, (s[0] && !o[0]) ? 1'h0 : 1'h1)
        `CK(wd, (s < 2) ? 1'h1 : 1'h0)
      end
    end
    opt = 1'h0;
    hst(1'h1, 4'hE, 10'h1F1);
    `CK(wd, 1'h0)
    `CK(e1, 1'h0)
    aen = 1'h1;
    #1;
    `CK(e1, 1'h1)
    aen = 1'h0;
    fin("decode");
    // drive selects: mirrors by default, address decoders when configured
    hst(1'h1, 4'hE, 10'h1F0);
    `CK(dl, 1'h0)
    hst(1'h1, 4'hB, 10'h3F6);
    `CK(dh, 1'h0)
    ca = 1'h1;
    cb = 1'h1;
    hst(1'h1, 4'hE, 10'h1F0);
    `CK(dl, 1'h1)
    hst(1'h1, 4'hF, 10'h2A0);
    `CK(dl, 1'h0)
    hst(1'h1, 4'hF, 10'h2A8);
    `CK(dh, 1'h0)
    fin("drive selects");
    // low byte through the internal buffer both ways
    byt = 8'hA5;
    hst(1'h1, 4'hE, 10'h1F0);
    `CK(sd_oe, 1'h1)
    tick(1);
    `CK(sd_out, 8'hA5)
    sd_in = 8'h3C;
    hst(1'h0, 4'hD, 10'h170);
    `CK(lo_oe, 1'h1)
    tick(1);
    `CK(lo_out, 8'h3C)
    hst(1'h1, 4'hF, 10'h000);
    ior = 1'h1;
    fin("data");
    // rom buffer: read, write with alternate pins, read only, isolated
    rdrv = 1'h1;
    rbyte = 8'h5A;
    cs = 1'h0;
    tick(2);
    `CK(sd_oe, 1'h1)
    `CK(roen, 8'h00)
    `CK(sd_out, 8'h5A)
    cs = 1'h1;
    alt = 8'h0F;
    aval = 8'h05;
    #1;
    `CK(roen, 8'h00)
    `CK(sd_oe, 1'h0)
    cs = 1'h0;
    dir = 1'h1;
    rdrv = 1'h0;
    sd_in = 8'hC3;
    tick(1);
    `CK(roen, 8'hFF)
    `CK(rout, 8'hC5)
    dir = 1'h0;
    rdrv = 1'h1;
    rbyte = 8'h96;
    tick(2);
    `CK(sd_out, 8'h96)
    oea = 1'h1;
    dir = 1'h1;
    rbyte = 8'h69;
    tick(2);
    `CK(roen, 8'h00)
    `CK(sd_out, 8'h69)
    cs = 1'h1;
    #1;
    `CK(sd_oe, 1'h0)
    for (int k = 0; k < 2; k++) begin
      oea = k[0];
      csa = 1'h1;
      cs = 1'h0;
      dir = 1'h0;
      tick(1);
      `CK(sd_oe, 1'h0)
      `CK(roen[7:4], 4'h0)
    end
    fin("rom buffer");
    // keyboard port pins: low drive, boost then pull-up, open drain
    rdrv = 1'h0;
    alt = 8'hFC;
    ksel = 8'hFC;
    tick(1);
    `CK(roen[7:2], 6'h3F)
    `CK(rout[7:2], 6'h00)
    gw = 8'hFC;
    gi = 8'hFC;
    tick(1);
    gw = 8'h00;
    tick(1);
    `CK(roen[7:2], 6'h3F)
    `CK(rout[7:2], 6'h00)
    kval = 8'h04;
    #1;
    `CK(rout[2], 1'h1)
    n = 0;
    while (roen[2] === 1'h1 && n < 20) begin
      n++;
      tick(1);
    end
    if (n == 20) begin
      miscompares++;
      final_report();
    end
    `CK(n, BST + 1)
    `CK(rpu[2], 1'h1)
    `CK(rin[2], 1'h1)
    kod = 8'h08;
    kval = 8'h0C;
    tick(3);
    `CK(roen[3], 1'h0)
    `CK(rpu[3], 1'h0)
    kval = 8'h04;
    #1;
    `CK(roen[3], 1'h1)
    `CK(rout[3], 1'h0)
    fin("port pins");
    // general pin configuration, then a second reset
    gw = 8'h01;
    go = 8'h01;
    gi = 8'h01;
    tick(1);
    gw = 8'h00;
    tick(1);
    `CK(gpo[0], 1'h1)
    `CK(gpi[0], 1'h1)
    `CK(rout[0], 1'h1)
    `CK(gin[0], 1'h0)
    rb = 1'h0;
    #1;
    `CK(gpo, 8'h00)
    `CK(gpi, 8'h00)
    tick(2);
    rb = 1'h1;
    fin("config and reset");
    final_report();
  end
endmodule
